// ===== hw/phy_rx_pkg.sv
// Functional notes
// - nrzi decode, unstuff, deserialize into bytes
// - reset holds packet-active and byte-valid low
// - after reset hunt sync, raise packet-active
// - accept sync of 4 or more zeros then a one, no upper limit
// - load holding register, pulse byte-valid
// - unstuff in mode 00; skipped bit time
// - eop drops strobes, then hunt again
// - packet-active falls after eop and drained buffer
// - byte-valid high only when holding register full
// - full speed: byte-valid one cycle per byte
// - receiver chosen by current operating speed
// - decode terminations; mode 01 forces all off
// - both pull-down requests: pull-downs on, pull-ups off
// - hs termination only speed 00 and term 0
// - peripheral term 1, speed 0x: d+ pull-up
// - peripheral speed 10: d- pull-up only
// - only d- request: d- pull-down plus mode settings
// - speed select picks hs or fs receive timing
package phy_rx_pkg;

  // ==========================================================
  // register map (word offsets on the wishbone bus)
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] status_offset = 4'h4;
  localparam logic [3:0] count_offset = 4'h8;

  // ==========================================================
  // control field positions and reset value
  localparam int speed_lsb = 0;
  localparam int term_bit = 2;
  localparam int operating_mode_sel_lsb = 3;
  localparam int dplus_pulldown_req_bit = 5;
  localparam int dminus_pulldown_req_bit = 6;
  localparam logic [6:0] ctrl_reset = 7'h61;

  // ==========================================================
  // encodings
  localparam logic [1:0] speed_hs = 2'h0;
  localparam logic [1:0] speed_ls = 2'h2;
  localparam logic [1:0] operating_mode_sel_normal = 2'h0;
  localparam logic [1:0] operating_mode_sel_tristate = 2'h1;

  // ==========================================================
  // receive timing counts
  localparam logic [2:0] stuff_ones = 3'h6;
  localparam logic [2:0] hs_eop_ones = 3'h7;
  localparam logic [4:0] sync_min_zeros = 5'h4;
  localparam logic [4:0] sync_max_zeros = 5'h1f;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic dminus_pulldown_req;
    logic dplus_pulldown_req;
    logic [1:0] operating_mode_sel;
    logic termination_sel;
    logic [1:0] transceiver_speed_sel;
  } term_ctrl_s;

  typedef struct packed {
    logic hs_termination_on;
    logic dminus_pulldown_on;
    logic dplus_pulldown_on;
    logic dminus_pullup_on;
    logic dplus_pullup_on;
  } term_en_s;

  typedef enum logic [1:0] {st_hunt, st_recv, st_strip} rx_state_e;

endpackage

// ===== hw/phy_rx_term.sv
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module phy_rx_term
  import phy_rx_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // recovered serial streams, one strobe per bit
  input wire logic hs_rx_bit,
  input wire logic hs_rx_strobe,
  input wire logic fs_rx_bit,
  input wire logic fs_rx_strobe,
  input wire logic fs_se0_pin,
  // byte interface to the link
  output logic [7:0] rx_data,
  output logic rx_packet_active,
  output logic rx_byte_valid,
  output logic rx_error_flag,
  // termination enables
  output term_en_s term_en
);

  // ==========================================================
  // registers
  // control first, then receive side, then termination and bus state
  term_ctrl_s ctrl_reg;
  rx_state_e state_reg;
  logic [1:0] se0_sync_reg;
  logic prev_level_reg;
  logic [2:0] ones_reg;
  logic [4:0] zeros_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic eop_seen_reg;
  logic error_reg;
  logic [15:0] byte_count_reg;
  term_en_s term_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // ==========================================================
  // receiver selection
  // combinational helpers, all on the one clock
  logic hs_mode;
  logic bit_in;
  logic bit_stb;
  logic decoded;
  logic normal_mode;
  logic stuffed;
  logic hs_eop;
  logic fs_stuff_err;
  logic fs_eop;
  logic take_bit;
  logic byte_done;
  logic wb_req;
  logic wb_wr;

  // speed select picks both the receiver and the timing used
  assign hs_mode = (ctrl_reg.transceiver_speed_sel == speed_hs);
  assign bit_in = hs_mode ? hs_rx_bit : fs_rx_bit;
  assign bit_stb = hs_mode ? hs_rx_strobe : fs_rx_strobe;
  assign normal_mode = (ctrl_reg.operating_mode_sel == operating_mode_sel_normal);

  // nrzi: no transition is a one, a transition is a zero
  assign decoded = (bit_in == prev_level_reg);

  // after six ones the next bit is a stuffed zero; a one there is
  // the hs eop pattern or a full-speed stuffing error
  assign stuffed = normal_mode && (ones_reg == stuff_ones) && !decoded;
  // hs eop only on a strobe: between strobes the held level decodes as a one
  assign hs_eop = hs_mode && normal_mode && bit_stb && (ones_reg == stuff_ones) &&
                  decoded;
  assign fs_stuff_err = !hs_mode && normal_mode && (ones_reg == stuff_ones) && decoded;
  assign fs_eop = !hs_mode && se0_sync_reg[1];

  // a data bit is one that is neither stuffing nor eop
  assign take_bit = (state_reg == st_recv) && bit_stb && !stuffed && !hs_eop && !fs_eop;
  assign byte_done = take_bit && (bit_cnt_reg == 3'h7);

  // ==========================================================
  // se0 comes straight from the line receiver: two flops first
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      se0_sync_reg <= 2'h0;
    end else begin
      se0_sync_reg <= {se0_sync_reg[0], fs_se0_pin};
    end
  end

  // ==========================================================
  // line level and run-length tracking
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prev_level_reg <= 1'b1;
      ones_reg <= 3'h0;
      zeros_reg <= 5'h0;
    end else if (bit_stb) begin
      prev_level_reg <= bit_in;
      // ones stop at seven: enough to tell eop from stuffing
      if (!decoded) begin
        ones_reg <= 3'h0;
      end else if (ones_reg != hs_eop_ones) begin
        ones_reg <= ones_reg + 3'h1;
      end
      // saturate so a long sync is never mistaken for garbage
      if (decoded) begin
        zeros_reg <= 5'h0;
      end else if (zeros_reg != sync_max_zeros) begin
        zeros_reg <= zeros_reg + 5'h1;
      end
    end
  end

  // ==========================================================
  // receive state machine
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= st_hunt;
    end else begin
      unique case (state_reg)
        st_hunt: begin
          // the trailing one of the sync after enough zeros
          if (bit_stb && decoded && zeros_reg >= sync_min_zeros) begin
            state_reg <= st_recv;
          end
        end
        st_recv: begin
          // either eop ends the packet; a byte already held still goes out
          if (hs_eop || fs_eop) begin
            state_reg <= st_strip;
          end
        end
        st_strip: begin
          // hs eop is gone once detected; fs waits out the se0
          // leave once the eop is on record and the last byte is out
          if (eop_seen_reg && !se0_sync_reg[1] && !hold_full_reg) begin
            state_reg <= st_hunt;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // serial to parallel, lsb first
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shift_reg <= 8'h0;
      bit_cnt_reg <= 3'h0;
    end else if (state_reg != st_recv) begin
      // a partial byte left at eop is dropped here
      bit_cnt_reg <= 3'h0;
    end else if (take_bit) begin
      shift_reg <= {decoded, shift_reg[7:1]};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // ==========================================================
  // holding register: full for exactly one cycle per byte, so the
  // valid strobe is one cycle per byte time at either speed
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hold_reg <= 8'h0;
      hold_full_reg <= 1'b0;
    end else begin
      hold_full_reg <= byte_done;
      if (byte_done) begin
        hold_reg <= {decoded, shift_reg[7:1]};
      end
    end
  end

  // ==========================================================
  // packet framing
  // remembers an eop until the receiver hunts again
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      eop_seen_reg <= 1'b0;
    end else if (state_reg == st_hunt) begin
      eop_seen_reg <= 1'b0;
    end else if (hs_eop || fs_eop) begin
      eop_seen_reg <= 1'b1;
    end
  end

  // error flag: stuffing violation in full speed, one cycle
  // in hs the same pattern is the eop, so it is no error there
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      error_reg <= 1'b0;
    end else begin
      error_reg <= (state_reg == st_recv) && bit_stb && fs_stuff_err;
    end
  end

  // bytes handed over since reset, visible to software
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      byte_count_reg <= 16'h0;
    end else if (hold_full_reg) begin
      byte_count_reg <= byte_count_reg + 16'h1;
    end
  end

  // the link takes the byte at the edge after valid rises; nothing
  // here waits for it, so the byte is assumed taken
  assign rx_data = hold_reg;
  // active drops only after eop and an empty holding register
  assign rx_packet_active = (state_reg == st_recv) ||
                            (state_reg == st_strip && hold_full_reg);
  assign rx_byte_valid = hold_full_reg && rx_packet_active;
  assign rx_error_flag = error_reg;

  // ==========================================================
  // termination decode, registered so the enables never glitch
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      term_reg <= '0;
    end else if (ctrl_reg.operating_mode_sel == operating_mode_sel_tristate) begin
      term_reg <= '0;
    end else begin
      // hs termination is the same in host and device roles
      term_reg.hs_termination_on <= (ctrl_reg.transceiver_speed_sel == speed_hs) &&
                                    !ctrl_reg.termination_sel;
      // host and power-up: pull-downs win, no pull-up may fight them
      if (ctrl_reg.dplus_pulldown_req && ctrl_reg.dminus_pulldown_req) begin
        term_reg.dplus_pulldown_on <= 1'b1;
        term_reg.dminus_pulldown_on <= 1'b1;
        term_reg.dplus_pullup_on <= 1'b0;
        term_reg.dminus_pullup_on <= 1'b0;
      end else begin
        // device roles: termination_sel picks the pull-up, speed picks its line
        term_reg.dplus_pulldown_on <= ctrl_reg.dplus_pulldown_req;
        term_reg.dminus_pulldown_on <= ctrl_reg.dminus_pulldown_req;
        term_reg.dplus_pullup_on <= ctrl_reg.termination_sel &&
                                    (ctrl_reg.transceiver_speed_sel != speed_ls);
        term_reg.dminus_pullup_on <= ctrl_reg.termination_sel &&
                                     (ctrl_reg.transceiver_speed_sel == speed_ls);
      end
    end
  end

  // enables leave straight from flops
  assign term_en = term_reg;

  // ==========================================================
  // wishbone slave: one wait state, ack drops the cycle after
  // a write lands on the edge that samples ack high, so a master that
  // drops the cycle before the answer writes nothing
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_wr = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // control register drives the decoder and the receiver choice
  // reset value is the power-up host setting: both pull-downs on
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_reg <= term_ctrl_s'(ctrl_reset);
    end else if (wb_wr && wb_adr_i == ctrl_offset) begin
      ctrl_reg <= term_ctrl_s'(wb_dat_i[6:0]);
    end
  end

  // read mux; unmapped words read zero and still acknowledge
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_reg <= 32'h0;
    end else if (wb_req) begin
      unique case (wb_adr_i)
        ctrl_offset: rdata_reg <= {25'h0, ctrl_reg};
        // status: term_en, packet active, holding full, error pulse
        status_offset: rdata_reg <= {24'h0, error_reg, hold_full_reg, rx_packet_active,
                                     term_reg};
        count_offset: rdata_reg <= {16'h0, byte_count_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end

  // bus outputs leave straight from flops
  assign wb_dat_o = rdata_reg;
  assign wb_ack_o = ack_reg;

endmodule

// ===== dv/phy_rx_term_asserts.sv
`timescale 1ns/100ps
module phy_rx_term_asserts
  import phy_rx_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // watched outputs
  input wire logic [7:0] rx_data,
  input wire logic rx_packet_active,
  input wire logic rx_byte_valid,
  input wire term_en_s term_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // receive strobes
  AST_RST_QUIET:
    assert property (disable iff (1'b0) !reset_n |=> !rx_packet_active && !rx_byte_valid)
    else $error("strobe high after reset edge");
  AST_VALID_PULSE:
    assert property (rx_byte_valid |=> !rx_byte_valid) else $error("byte valid too long");
  AST_VALID_IN_PKT:
    assert property (rx_byte_valid |-> rx_packet_active) else $error("valid outside packet");
  AST_DATA_HOLD:
    assert property ($changed(rx_data) |-> rx_byte_valid) else $error("data moved silently");
  AST_ACTIVE_RISE:
    assert property ($rose(rx_packet_active) |-> !rx_byte_valid) else $error("valid at sync");
  AST_EOP_DROP:
    assert property ($fell(rx_packet_active) |-> !rx_byte_valid) else $error("valid at eop");
  // ==========================================================
  // termination enables, a pull-up never meets hs termination
  AST_HS_NO_PU:
    assert property (term_en.hs_termination_on |-> !term_en.dplus_pullup_on
      && !term_en.dminus_pullup_on) else $error("pull-up with hs termination");
  AST_PU_EXCL:
    assert property (!(term_en.dplus_pullup_on && term_en.dminus_pullup_on))
    else $error("both pull-ups on");
  AST_BOTH_PD:
    assert property (term_en.dplus_pulldown_on && term_en.dminus_pulldown_on
      |-> !term_en.dplus_pullup_on && !term_en.dminus_pullup_on) else $error("host pull-up");
  COV_RISE: cover property ($rose(rx_packet_active));
  COV_BYTE: cover property (rx_byte_valid);
  COV_FALL: cover property ($fell(rx_packet_active));
endmodule
bind phy_rx_term phy_rx_term_asserts chk (.clock(clock), .reset_n(reset_n), .rx_data(rx_data),
  .rx_packet_active(rx_packet_active), .rx_byte_valid(rx_byte_valid), .term_en(term_en));

// ===== dv/link_model.sv
`timescale 1ns/100ps
module link_model
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // byte interface
  input wire logic [7:0] rx_data,
  input wire logic rx_packet_active,
  input wire logic rx_byte_valid,
  // what was taken
  output logic [15:0] last_bytes,
  output logic [7:0] byte_count
);
  // takes a byte on every edge with both strobes, never stalls
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      last_bytes <= 16'h0000;
      byte_count <= 8'h00;
    end else if (rx_packet_active && rx_byte_valid) begin
      last_bytes <= {last_bytes[7:0], rx_data};
      byte_count <= byte_count + 8'h01;
    end
  end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench
  import phy_rx_pkg::*;
;
  logic clock = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, se0 = 0, line = 1, ack;
  logic hs_bit = 1, hs_stb = 0, fs_bit = 1, fs_stb = 0;
  logic [3:0] adr = 4'h0, sel = 4'h1, lanes = 4'h1;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [7:0] rx_data, cnt;
  logic rx_packet_active, rx_byte_valid;
  logic [15:0] seen;
  term_en_s term_en;
  int n_errors = 0, n_compared = 0, cycles = 0, ones = 0;
  // ==========================================================
  // clock and hang guard
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  phy_rx_term dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .hs_rx_bit(hs_bit), .hs_rx_strobe(hs_stb), .fs_rx_bit(fs_bit),
    .fs_rx_strobe(fs_stb), .fs_se0_pin(se0), .rx_data(rx_data),
    .rx_packet_active(rx_packet_active), .rx_byte_valid(rx_byte_valid),
    .rx_error_flag(), .term_en(term_en));
  link_model link (.clock(clock), .reset_n(reset_n), .rx_data(rx_data),
    .rx_packet_active(rx_packet_active), .rx_byte_valid(rx_byte_valid),
    .last_bytes(seen), .byte_count(cnt));
  // ==========================================================
  // shared tasks
  task check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, lanes};
    do @(posedge clock); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clock);
  endtask
  // unselected receiver sees a constant line, which decodes to ones only
  task bit_out(input logic b, input logic hs);
    if (!b) line = ~line;
    @(posedge clock);
    {hs_bit, fs_bit, hs_stb, fs_stb} <= {hs ? line : 1'b1, hs ? 1'b1 : line, 2'b11};
    @(posedge clock);
    {hs_stb, fs_stb} <= 2'b00;
    repeat (hs ? 0 : 2) @(posedge clock);
  endtask
  task byte_out(input logic [7:0] v, input logic hs);
    for (int i = 0; i < 8; i++) begin
      bit_out(v[i], hs);
      ones = v[i] ? ones + 1 : 0;
      if (ones == 6) begin
        bit_out(1'b0, hs);
        ones = 0;
      end
    end
  endtask
  task sync_out(input int zeros, input logic hs);
    repeat (zeros) bit_out(1'b0, hs);
    bit_out(1'b1, hs);
    ones = 1;
    @(posedge clock);
    check(rx_packet_active, 1'b1);
  endtask
  // ==========================================================
  // scenarios
  task term_table();
    logic [6:0] c [8] = '{7'h60, 7'h68, 7'h05, 7'h06, 7'h45, 7'h40, 7'h04, 7'h70};
    logic [4:0] e [8] = '{5'h1c, 5'h00, 5'h01, 5'h02, 5'h09, 5'h18, 5'h01, 5'h1c};
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, 4'h0, {25'h0, c[i]});
      wb(1'b0, 4'h4, 32'h0);
      check(term_en, e[i]);
      check(q[4:0], e[i]);
    end
    wb(1'b0, 4'hc, 32'h0);
    check(q, 32'h0);
    // a write without its low byte lane must leave control alone
    lanes = 4'h0;
    wb(1'b1, 4'h0, 32'h68);
    lanes = 4'h1;
    wb(1'b0, 4'h0, 32'h0);
    check(q, 32'h70);
  endtask
  // stuffed zero inside 0x3f must not make a byte; seven ones end the packet
  task pkt_hs(input int zeros, input logic [7:0] n);
    sync_out(zeros, 1'b1);
    byte_out(8'ha5, 1'b1);
    byte_out(8'h3f, 1'b1);
    repeat (8) bit_out(1'b1, 1'b1);
    repeat (4) @(posedge clock);
    check(rx_packet_active, 1'b0);
    check(cnt, n);
    check(seen, 16'ha53f);
  endtask
  task pkt_fs();
    wb(1'b1, 4'h0, 32'h61);
    sync_out(7, 1'b0);
    byte_out(8'h5a, 1'b0);
    se0 <= 1'b1;
    repeat (3) @(posedge clock);
    se0 <= 1'b0;
    repeat (6) @(posedge clock);
    check(rx_packet_active, 1'b0);
    check(cnt, 8'h05);
    check(seen[7:0], 8'h5a);
  endtask
  task results();
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    check({rx_packet_active, rx_byte_valid}, 2'b00);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    check(term_en, 5'h0c);
    term_table();
    wb(1'b1, 4'h0, 32'h60);
    pkt_hs(11, 8'h02);
    pkt_hs(31, 8'h04);
    pkt_fs();
    results();
  end
endmodule
